// ### hw/tcc_pkg.sv
// Notes on behaviour
// - edge/level bits 00 release pin to port
// - with 00, compare-select picks initial level
// - capture edges: 01 rise, 10 fall, 11 both
// - compare action: 01 toggle, 10 clear, 11 set
// - mode from buffered and compare select bits
// - reset clears edge/level bits on every channel
// - toggle-on-overflow in compare modes, reset clears
// - overflow action beats simultaneous compare action
// - max duty forces 100% unless overflow toggling
// - max duty change applies at next period
// - value registers hold capture or compare, uninitialised
// - capture high read blocks captures until low
// - compare high write blocks matches until low
// - buffered select on 0,2 disables odd partner
// - flag on active capture edge or match
package tcc_pkg;

    localparam int                    TCC_NCH        = 4;
    localparam int                    TCC_CW         = 16;
    localparam logic [1:0]            TCC_HTRANS_NSQ = 2'h2;
    // register byte offsets, one word each
    localparam logic [7:0]            TCC_CTRL_BASE  = 8'h00;
    localparam logic [7:0]            TCC_VAL_BASE   = 8'h10;
    localparam logic [7:0]            TCC_ADDR_END   = 8'h30;
    // control word field positions
    localparam int                    TCC_F_FLAG     = 7;
    localparam int                    TCC_F_BSEL     = 5;
    localparam int                    TCC_F_CSEL     = 4;
    localparam int                    TCC_F_ELSH     = 3;
    localparam int                    TCC_F_ELSL     = 2;
    localparam int                    TCC_F_TOV      = 1;
    localparam int                    TCC_F_MAX      = 0;
    localparam logic                  TCC_CTRL_RST   = 1'b0;

    typedef enum logic [3:0] {
        TCC_M_PORT = 4'b0001,
        TCC_M_CAPT = 4'b0010,
        TCC_M_CMP  = 4'b0100,
        TCC_M_BUF  = 4'b1000
    } tcc_mode_t;

    localparam logic [1:0]            TCC_ACT_TOGGLE = 2'h1;
    localparam logic [1:0]            TCC_ACT_CLEAR  = 2'h2;
    localparam logic [1:0]            TCC_ACT_SET    = 2'h3;

    function automatic tcc_mode_t tcc_decode(input logic bsel, input logic csel,
                                             input logic [1:0] els, input logic dis);
        tcc_mode_t m;
        m = TCC_M_PORT;
        if (!dis && els != 2'h0) begin
            if (bsel)      m = TCC_M_BUF;
            else if (csel) m = TCC_M_CMP;
            else           m = TCC_M_CAPT;
        end
        return m;
    endfunction : tcc_decode

endpackage : tcc_pkg

// ### hw/tcc_edge_if.sv
`timescale 1ns/100ps
interface tcc_edge_if;
    logic [3:0] pins;
    logic [3:0] rise_en;
    logic [3:0] fall_en;
    logic [3:0] hit;
    modport det   (input pins, input rise_en, input fall_en, output hit);
    modport owner (output pins, output rise_en, output fall_en, input hit);
endinterface : tcc_edge_if

// ### hw/tcc_edge_detect.sv
`timescale 1ns/100ps
module tcc_edge_detect (
    input wire logic i_clock,
    input wire logic i_rst,
    tcc_edge_if.det  edge_bus
);
    // ========================================
    // edge detection per channel pin
    logic [3:0] prev_ff;

    // pins are synchronous to the clock, so one delay stage is enough
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            prev_ff <= 4'h0;
        end else begin
            prev_ff <= edge_bus.pins;
        end
    end

    assign edge_bus.hit = (edge_bus.rise_en & edge_bus.pins & ~prev_ff)
                        | (edge_bus.fall_en & ~edge_bus.pins & prev_ff);

endmodule : tcc_edge_detect

// ### hw/tcc_channel_top.sv
`timescale 1ns/100ps
module tcc_channel_top (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic [31:0]      o_hrdata,
    input  wire logic [15:0] i_count,
    input  wire logic        i_count_update,
    input  wire logic        i_overflow,
    input  wire logic [3:0]  i_channel_pin,
    output logic [3:0]       o_channel_pin,
    output logic [3:0]       o_channel_pin_oe,
    output logic [3:0]       o_port_release,
    output logic [3:0]       o_channel_event_flag
);
    // ========================================
    // channel control state
    logic                   flag_ff [4];
    logic                   arm_ff  [4];
    logic                   bsel_ff [4];
    logic                   csel_ff [4];
    logic [1:0]             els_ff  [4];
    logic                   tov_ff  [4];
    logic                   max_ff  [4];
    logic                   maxe_ff [4];
    logic                   out_ff  [4];
    logic                   rdlk_ff [4];
    logic                   wrin_ff [4];
    logic [15:0]            val_ff  [4];
    logic                   act_ff  [2];
    logic                   last_ff [2];
    tcc_pkg::tcc_mode_t     mode    [4];
    logic                   dis     [4];
    logic [15:0]            cmpv    [4];
    logic                   match   [4];
    logic                   cap     [4];

    // ========================================
    // bus front end
    logic                   acc;
    logic                   addr_ok;
    logic [3:0]             ridx;
    logic                   wr_pend_ff;
    logic [3:0]             widx_ff;
    logic                   wr_ctrl;
    logic                   wr_vhi;
    logic                   wr_vlo;
    logic [1:0]             wch;
    logic                   rd_ctrl;
    logic                   rd_vhi;
    logic                   rd_vlo;
    logic [1:0]             rch;
    logic [31:0]            rd_mux;

    assign acc     = i_hsel & i_hready & (i_htrans == tcc_pkg::TCC_HTRANS_NSQ);
    assign addr_ok = (i_haddr[31:8] == 24'h00_0000) && (i_haddr[7:0] < tcc_pkg::TCC_ADDR_END);
    assign ridx    = i_haddr[5:2];
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    // index 0..3 are control words, 4..11 alternate value high and low
    function automatic logic is_ctrl(input logic [3:0] idx);
        return idx < tcc_pkg::TCC_VAL_BASE[5:2];
    endfunction : is_ctrl

    function automatic logic [1:0] val_ch(input logic [3:0] idx);
        logic [3:0] off;
        off = idx - tcc_pkg::TCC_VAL_BASE[5:2];
        return off[2:1];
    endfunction : val_ch

    assign rd_ctrl = acc & ~i_hwrite & addr_ok & is_ctrl(ridx);
    assign rd_vhi  = acc & ~i_hwrite & addr_ok & ~is_ctrl(ridx) & ~ridx[0];
    assign rd_vlo  = acc & ~i_hwrite & addr_ok & ~is_ctrl(ridx) & ridx[0];
    assign rch     = is_ctrl(ridx) ? ridx[1:0] : val_ch(ridx);
    assign wr_ctrl = wr_pend_ff & is_ctrl(widx_ff);
    assign wr_vhi  = wr_pend_ff & ~is_ctrl(widx_ff) & ~widx_ff[0];
    assign wr_vlo  = wr_pend_ff & ~is_ctrl(widx_ff) & widx_ff[0];
    assign wch     = is_ctrl(widx_ff) ? widx_ff[1:0] : val_ch(widx_ff);

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            wr_pend_ff <= 1'b0;
            widx_ff    <= 4'h0;
        end else begin
            wr_pend_ff <= acc & i_hwrite & addr_ok;
            widx_ff    <= ridx;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (rd_ctrl) begin
            rd_mux[tcc_pkg::TCC_F_FLAG] = flag_ff[rch];
            rd_mux[tcc_pkg::TCC_F_BSEL] = bsel_ff[rch];
            rd_mux[tcc_pkg::TCC_F_CSEL] = csel_ff[rch];
            rd_mux[tcc_pkg::TCC_F_ELSH] = els_ff[rch][1];
            rd_mux[tcc_pkg::TCC_F_ELSL] = els_ff[rch][0];
            rd_mux[tcc_pkg::TCC_F_TOV]  = tov_ff[rch];
            rd_mux[tcc_pkg::TCC_F_MAX]  = max_ff[rch];
        end else if (rd_vhi) begin
            rd_mux[7:0] = val_ff[rch][15:8];
        end else if (rd_vlo) begin
            rd_mux[7:0] = val_ff[rch][7:0];
        end
    end

    // read data is registered at the address phase, so no wait states
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_hrdata <= 32'h0000_0000;
        end else if (acc & ~i_hwrite) begin
            o_hrdata <= rd_mux;
        end
    end

    // ========================================
    // mode decode and compare selection
    assign dis[0] = 1'b0;
    assign dis[1] = bsel_ff[0];
    assign dis[2] = 1'b0;
    assign dis[3] = bsel_ff[2];

    always_comb begin
        for (int c = 0; c < 4; c++) begin
            mode[c] = tcc_pkg::tcc_decode(bsel_ff[c], csel_ff[c], els_ff[c], dis[c]);
            cmpv[c] = val_ff[c];
            match[c] = 1'b0;
        end
        for (int p = 0; p < 2; p++) begin
            if (act_ff[p]) begin
                cmpv[2*p] = val_ff[2*p+1];
            end
        end
        for (int c = 0; c < 4; c++) begin
            match[c] = i_count_update && (i_count == cmpv[c]) && !wrin_ff[c]
                     && (mode[c] == tcc_pkg::TCC_M_CMP || mode[c] == tcc_pkg::TCC_M_BUF);
        end
    end

    // ========================================
    // capture edge detection
    tcc_edge_if edge_bus ();

    always_comb begin
        edge_bus.pins = i_channel_pin;
        for (int c = 0; c < 4; c++) begin
            edge_bus.rise_en[c] = els_ff[c][0];
            edge_bus.fall_en[c] = els_ff[c][1];
            cap[c] = edge_bus.hit[c] && (mode[c] == tcc_pkg::TCC_M_CAPT) && !rdlk_ff[c];
        end
    end

    tcc_edge_detect u_edge (
        .i_clock  (i_clock),
        .i_rst    (i_rst),
        .edge_bus (edge_bus.det)
    );

    // ========================================
    // control registers
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            for (int c = 0; c < 4; c++) begin
                bsel_ff[c] <= tcc_pkg::TCC_CTRL_RST;
                csel_ff[c] <= tcc_pkg::TCC_CTRL_RST;
                els_ff[c]  <= 2'h0;
                tov_ff[c]  <= tcc_pkg::TCC_CTRL_RST;
                max_ff[c]  <= tcc_pkg::TCC_CTRL_RST;
            end
        end else if (wr_ctrl) begin
            bsel_ff[wch] <= (wch[0] == 1'b0) & i_hwdata[tcc_pkg::TCC_F_BSEL];
            csel_ff[wch] <= i_hwdata[tcc_pkg::TCC_F_CSEL];
            els_ff[wch]  <= {i_hwdata[tcc_pkg::TCC_F_ELSH], i_hwdata[tcc_pkg::TCC_F_ELSL]};
            tov_ff[wch]  <= i_hwdata[tcc_pkg::TCC_F_TOV];
            max_ff[wch]  <= i_hwdata[tcc_pkg::TCC_F_MAX];
        end
    end

    // flag clears only by a zero write after reading it set; a new event wins
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            for (int c = 0; c < 4; c++) begin
                flag_ff[c] <= 1'b0;
                arm_ff[c]  <= 1'b0;
            end
        end else begin
            for (int c = 0; c < 4; c++) begin
                if (cap[c] || match[c]) begin
                    flag_ff[c] <= 1'b1;
                end else if (wr_ctrl && wch == c[1:0] && arm_ff[c] && !i_hwdata[tcc_pkg::TCC_F_FLAG]) begin
                    flag_ff[c] <= 1'b0;
                end
                if (rd_ctrl && rch == c[1:0]) begin
                    arm_ff[c] <= flag_ff[c];
                end else if (wr_ctrl && wch == c[1:0]) begin
                    arm_ff[c] <= 1'b0;
                end
            end
        end
    end

    // ========================================
    // value registers: no reset, contents unknown until used
    always_ff @(posedge i_clock) begin
        for (int c = 0; c < 4; c++) begin
            if (cap[c]) begin
                val_ff[c] <= i_count;
            end else if (wr_vhi && wch == c[1:0]) begin
                val_ff[c][15:8] <= i_hwdata[7:0];
            end else if (wr_vlo && wch == c[1:0]) begin
                val_ff[c][7:0] <= i_hwdata[7:0];
            end
        end
    end

    // byte interlocks keep a 16-bit value coherent across two accesses
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            for (int c = 0; c < 4; c++) begin
                rdlk_ff[c] <= 1'b0;
                wrin_ff[c] <= 1'b0;
            end
        end else begin
            for (int c = 0; c < 4; c++) begin
                if (rd_vlo && rch == c[1:0]) begin
                    rdlk_ff[c] <= 1'b0;
                end else if (rd_vhi && rch == c[1:0] && mode[c] == tcc_pkg::TCC_M_CAPT) begin
                    rdlk_ff[c] <= 1'b1;
                end
                if (wr_vlo && wch == c[1:0]) begin
                    wrin_ff[c] <= 1'b0;
                end else if (wr_vhi && wch == c[1:0] && !csel_ff[c] && !bsel_ff[c] && !dis[c]) begin
                    wrin_ff[c] <= 1'b0;
                end else if (wr_vhi && wch == c[1:0]) begin
                    wrin_ff[c] <= 1'b1;
                end
            end
        end
    end

    // ========================================
    // buffered pairs: the register written last becomes active at overflow
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            for (int p = 0; p < 2; p++) begin
                act_ff[p]  <= 1'b0;
                last_ff[p] <= 1'b0;
            end
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (wr_vlo && wch[1] == p[0]) begin
                    last_ff[p] <= wch[0];
                end
                if (mode[2*p] != tcc_pkg::TCC_M_BUF) begin
                    act_ff[p] <= 1'b0;
                end else if (i_overflow) begin
                    act_ff[p] <= last_ff[p];
                end
            end
        end
    end

    // ========================================
    // channel output logic
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            for (int c = 0; c < 4; c++) begin
                maxe_ff[c] <= 1'b0;
                out_ff[c]  <= 1'b1;
            end
        end else begin
            for (int c = 0; c < 4; c++) begin
                if (i_overflow) begin
                    maxe_ff[c] <= max_ff[c];
                end
                if (mode[c] == tcc_pkg::TCC_M_PORT) begin
                    out_ff[c] <= ~csel_ff[c];
                end else if (mode[c] != tcc_pkg::TCC_M_CAPT) begin
                    if (maxe_ff[c] && !tov_ff[c]) begin
                        out_ff[c] <= 1'b1;
                    end else if (i_overflow && tov_ff[c]) begin
                        out_ff[c] <= ~out_ff[c];
                    end else if (match[c]) begin
                        case (els_ff[c])
                            tcc_pkg::TCC_ACT_TOGGLE: out_ff[c] <= ~out_ff[c];
                            tcc_pkg::TCC_ACT_CLEAR:  out_ff[c] <= 1'b0;
                            tcc_pkg::TCC_ACT_SET:    out_ff[c] <= 1'b1;
                            default:                 out_ff[c] <= out_ff[c];
                        endcase
                    end
                end
            end
        end
    end

    always_comb begin
        for (int c = 0; c < 4; c++) begin
            o_channel_pin[c]        = out_ff[c];
            o_channel_pin_oe[c]     = (mode[c] == tcc_pkg::TCC_M_CMP) || (mode[c] == tcc_pkg::TCC_M_BUF);
            o_port_release[c]       = (mode[c] == tcc_pkg::TCC_M_PORT);
            o_channel_event_flag[c] = flag_ff[c];
        end
    end

    // ========================================
    // assertions
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    property p_release;
        (els_ff[0] == 2'h0) |-> (o_port_release[0] && !o_channel_pin_oe[0]);
    endproperty
    a_release: assert property (p_release) else $error("pin not released with edge bits zero");

    property p_init_low;
        (els_ff[1] == 2'h0 && csel_ff[1]) ##1 (els_ff[1] == 2'h0 && csel_ff[1]) |-> !o_channel_pin[1];
    endproperty
    a_init_low: assert property (p_init_low) else $error("initial level not low");

    property p_capture;
        cap[0] |=> (val_ff[0] == $past(i_count));
    endproperty
    a_capture: assert property (p_capture) else $error("capture lost counter value");

    property p_toggle;
        (match[1] && els_ff[1] == 2'h1 && !maxe_ff[1] && !(i_overflow && tov_ff[1]))
            |=> (o_channel_pin[1] != $past(o_channel_pin[1]));
    endproperty
    a_toggle: assert property (p_toggle) else $error("compare toggle missing");

    property p_ovf_first;
        (i_overflow && tov_ff[1] && !maxe_ff[1] && mode[1] == tcc_pkg::TCC_M_CMP && match[1] && els_ff[1] == 2'h3)
            |=> (o_channel_pin[1] == !$past(o_channel_pin[1]));
    endproperty
    a_ovf_first: assert property (p_ovf_first) else $error("overflow did not take precedence");

    property p_max;
        (maxe_ff[2] && !tov_ff[2] && mode[2] == tcc_pkg::TCC_M_CMP)[*2] |-> o_channel_pin[2];
    endproperty
    a_max: assert property (p_max) else $error("max duty not forced high");

    property p_lock;
        rdlk_ff[0] |=> $stable(val_ff[0]) || $past(wr_pend_ff);
    endproperty
    a_lock: assert property (p_lock) else $error("capture while high byte locked");

    property p_inhibit;
        wrin_ff[1] |-> !match[1];
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("match while high byte pending");

    property p_pair_off;
        bsel_ff[2] |-> (o_port_release[3] && !o_channel_pin_oe[3]);
    endproperty
    a_pair_off: assert property (p_pair_off) else $error("partner channel not disabled");

    property p_flag;
        (cap[1] || match[1]) |=> flag_ff[1];
    endproperty
    a_flag: assert property (p_flag) else $error("flag not set on event");

endmodule : tcc_channel_top

// ### bench/tcc_pin_model.sv
`timescale 1ns/100ps
module tcc_pin_model (
    input  wire logic       i_clock,
    input  wire logic [3:0] i_level,
    input  wire logic [3:0] i_drive,
    input  wire logic [3:0] i_oe,
    output logic [3:0]      o_pin
);
    // ==========
    // external sources on the channel pins
    logic [3:0] src_ff;
    // a source level moves only on a clock edge, so it stands a full clock before any sampling
    always_ff @(posedge i_clock) src_ff <= i_level;
    // a pin the channel drives shows the channel's level, any other one the source's level
    assign o_pin = (i_oe & i_drive) | (~i_oe & src_ff);
endmodule : tcc_pin_model

// ### bench/tcc_tb.sv
`timescale 1ns/100ps
module tb;
    // ==========
    // signals
    logic        i_clock = 1'b0, i_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, upd = 1'b0, ovf = 1'b0;
    logic [1:0]  htrans  = 2'h0;
    logic [31:0] haddr   = 32'h0000_0000, hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd;
    logic        hready, init;
    logic [15:0] count   = 16'h0000;
    logic [15:0] va, vb;
    logic [3:0]  lvl     = 4'h0;
    logic [3:0]  pin_in, pin_out, oe, rel, flag;
    logic [7:0]  hi;
    integer      error_cnt = 0, cmp_count = 0, seed = 32'h7daa_0a36;

    tcc_channel_top u_tcc_channel_top (
        .i_clock(i_clock), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
        .o_hresp(), .o_hrdata(hrdata), .i_count(count), .i_count_update(upd), .i_overflow(ovf),
        .i_channel_pin(pin_in), .o_channel_pin(pin_out), .o_channel_pin_oe(oe),
        .o_port_release(rel), .o_channel_event_flag(flag)
    );
    tcc_pin_model u_tcc_pin_model (
        .i_clock(i_clock), .i_level(lvl), .i_drive(pin_out), .i_oe(oe), .o_pin(pin_in)
    );

    always #20 i_clock = ~i_clock;

    // ==========
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        hsel   <= 1'b1;
        htrans <= tcc_pkg::TCC_HTRANS_NSQ;
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge i_clock); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge i_clock); while (hready !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
        // a write lands on this very edge, so let it settle before the caller looks
        #1;
    endtask : bus

    // lets the edge's own updates land before anything is looked at
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : tick

    task automatic pulse(input logic [15:0] c, input logic o);
        @(posedge i_clock);
        count <= c;
        upd   <= 1'b1;
        ovf   <= o;
        @(posedge i_clock);
        upd <= 1'b0;
        ovf <= 1'b0;
        tick(2);
    endtask : pulse

    function automatic logic [15:0] cap_exp(input int e, input logic [15:0] a, input logic [15:0] b);
        return (e == 1) ? a : b;
    endfunction : cap_exp

    function automatic logic cmp_exp(input int e, input logic start);
        return (e == 1) ? ~start : (e == 3);
    endfunction : cmp_exp

    task automatic close_out;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    initial begin
        #(40 * 3000);
        error_cnt++;
        close_out();
    end

    // ==========
    // main sequence
    initial begin
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        tick(1);
        chk(32'({rel, pin_out, oe}), 32'h0000_0ff0);
        for (int n = 0; n < 4; n++) begin
            bus(1'b0, 8'(4 * n), 32'h0000_0000);
            chk(rd, 32'h0000_0000);
        end
        bus(1'b1, 8'h40, 32'hffff_ffff);
        bus(1'b0, 8'h40, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        // ==========
        // capture, one pass per edge selection
        for (int e = 1; e < 4; e++) begin
            va = 16'($random(seed));
            vb = 16'($random(seed));
            bus(1'b0, 8'h00, 32'h0000_0000);
            bus(1'b1, 8'h00, 32'(e << 2));
            chk(32'({oe[0], rel[0], flag[0]}), 32'h0000_0000);
            count  <= va;
            lvl[0] <= 1'b1;
            tick(4);
            chk(32'(flag[0]), 32'(e != 2));
            count  <= vb;
            lvl[0] <= 1'b0;
            tick(4);
            bus(1'b0, 8'h10, 32'h0000_0000);
            hi = rd[7:0];
            bus(1'b0, 8'h14, 32'h0000_0000);
            chk({16'h0000, hi, rd[7:0]}, 32'(cap_exp(e, va, vb)));
        end
        bus(1'b0, 8'h10, 32'h0000_0000);
        count  <= ~vb;
        lvl[0] <= 1'b1;
        tick(4);
        bus(1'b0, 8'h14, 32'h0000_0000);
        chk(32'(rd[7:0]), 32'(vb[7:0]));
        // ==========
        // unbuffered compare, one pass per action
        for (int e = 1; e < 4; e++) begin
            init = (e == 2);
            va   = 16'($random(seed));
            bus(1'b0, 8'h04, 32'h0000_0000);
            bus(1'b1, 8'h04, init ? 32'h0000_0000 : 32'h0000_0010);
            tick(2);
            chk(32'(pin_out[1]), 32'(init));
            bus(1'b1, 8'h18, 32'(va[15:8]));
            bus(1'b1, 8'h1c, 32'(va[7:0]));
            bus(1'b1, 8'h04, 32'h0000_0010 | 32'(e << 2));
            pulse(va + 16'h0001, 1'b0);
            chk(32'({oe[1], rel[1], flag[1], pin_out[1]}), 32'({3'b100, init}));
            pulse(va, 1'b0);
            chk(32'({flag[1], pin_out[1]}), 32'({1'b1, cmp_exp(e, init)}));
        end
        vb = ~va;
        bus(1'b1, 8'h04, 32'h0000_0014);
        bus(1'b1, 8'h18, 32'(vb[15:8]));
        pulse(va, 1'b0);
        // the half-written value would match here if the inhibit were missing
        pulse({vb[15:8], va[7:0]}, 1'b0);
        chk(32'(pin_out[1]), 32'h0000_0001);
        bus(1'b1, 8'h1c, 32'(vb[7:0]));
        pulse(vb, 1'b0);
        chk(32'(pin_out[1]), 32'h0000_0000);
        bus(1'b1, 8'h04, 32'h0000_0016);
        pulse(va, 1'b1);
        chk(32'(pin_out[1]), 32'h0000_0001);
        bus(1'b1, 8'h04, 32'h0000_001e);
        pulse(vb, 1'b1);
        chk(32'(pin_out[1]), 32'h0000_0000);
        // ==========
        // forced full duty on channel 2
        va = 16'($random(seed));
        bus(1'b1, 8'h08, 32'h0000_0010);
        bus(1'b1, 8'h20, 32'(va[15:8]));
        bus(1'b1, 8'h24, 32'(va[7:0]));
        bus(1'b1, 8'h08, 32'h0000_0019);
        tick(2);
        chk(32'(pin_out[2]), 32'h0000_0000);
        pulse(~va, 1'b1);
        pulse(va, 1'b0);
        chk(32'(pin_out[2]), 32'h0000_0001);
        bus(1'b1, 8'h08, 32'h0000_0018);
        pulse(va, 1'b0);
        chk(32'(pin_out[2]), 32'h0000_0001);
        pulse(~va, 1'b1);
        pulse(va, 1'b0);
        chk(32'(pin_out[2]), 32'h0000_0000);
        // ==========
        // buffered pair 2/3
        bus(1'b1, 8'h0c, 32'h0000_0014);
        bus(1'b1, 8'h08, 32'h0000_0024);
        tick(2);
        chk(32'({rel[3], oe[3], oe[2]}), 32'h0000_0005);
        vb = ~va;
        bus(1'b1, 8'h28, 32'(vb[15:8]));
        bus(1'b1, 8'h2c, 32'(vb[7:0]));
        pulse(va ^ 16'h0001, 1'b1);
        pulse(va, 1'b0);
        chk(32'(pin_out[2]), 32'h0000_0000);
        pulse(vb, 1'b0);
        chk(32'(pin_out[2]), 32'h0000_0001);
        close_out();
    end
endmodule : tb
